// ==== logic/core_interrupt_controller.sv ====
// Operation
// - Eleven request sources are accepted
// - Global disable set blocks every interrupt
// - Accept sets disable, pushes, loads vector
// - Four vectors, one shared by peripherals
// - Vectoring clears ext, timer0, counter flags
// - Flags set regardless of enables
// - External events see a response latency
// - Return pops stack, clears global disable
// - Bit 7 reads OR of enabled peripheral flags
// - Bit 3 gates all peripheral interrupts
// - Flag set while enable cleared forces reset when global disable is clear
// - Bit 4 external pin edge flag
// - Bit 6 counter pin edge flag
// - Bit 5 timer0 overflow flag
// - Enable bits 2, 1, 0 gate requests
// - Wake leaves the waking flag set
// - Wake with disable clear takes vector
// - Status/control register at 07h, layout fixed
// - Priority ext, timer0, counter, peripherals
// - Reset sets global disable
// - Global disable is core status bit 4
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
module core_interrupt_controller
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Pins
  input  wire logic        extIrqPin,
  input  wire logic        counterClockPin,
  // Request sources on mclk
  input  wire logic        timer0Overflow,
  input  wire logic [7:0]  periphEvent,
  // Core sequencer
  input  wire logic        irqAccept,
  input  wire logic        returnOp,
  output logic             irqRequest,
  output logic [15:0]      vectorAddr,
  output logic             vectorLoad,
  output logic             stackPush,
  output logic             stackPop,
  output logic             forceReset,
  output logic             wakeUp,
  output logic             globalIrqDisable
);

  addr_phase_type  aphase_r;
  logic [7:0]      isc_r;
  logic [7:0]      pir_r;
  logic [7:0]      pie_r;
  logic [1:0]      edgeSel_r;
  logic            gid_r;
  logic [2:0]      extSync_r;
  logic [2:0]      cntSync_r;
  logic [15:0]     vector_r;
  logic            vectorLoad_r;
  logic            push_r;
  logic            pop_r;
  logic            forceReset_r;
  logic            wake_r;
  logic [31:0]     rdata_r;
  logic            extEdge;
  logic            cntEdge;
  logic            periphPend;
  logic [3:0]      enabledReq;
  logic            anyEnabled;
  src_type         sel;
  logic            take;
  logic            wrEn;
  logic            wrIsc;
  logic [7:0]      wdat;
  logic [2:0]      flagSet;
  logic [2:0]      flagClr;
  logic [7:0]      iscRead;
  logic            rdTake;

  // Bus: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      aphase_r <= '0;
    else if (hready)
    begin
      aphase_r.active  <= hsel && htrans[1];
      aphase_r.write   <= hwrite;
      aphase_r.index   <= haddr[9:2];
      aphase_r.aligned <= (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
    end
  end

  assign wrEn  = aphase_r.active && aphase_r.write && aphase_r.aligned;
  assign wrIsc = wrEn && (aphase_r.index == IRQ_STATUS_IDX);
  assign wdat  = hwdata[7:0];

  // Pins pass two flops; third stage is the edge reference
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      extSync_r <= 3'h0;
      cntSync_r <= 3'h0;
    end
    else
    begin
      extSync_r <= {extSync_r[1:0], extIrqPin};
      cntSync_r <= {cntSync_r[1:0], counterClockPin};
    end
  end

  assign extEdge = edgeSel_r[1] ? (extSync_r[1] && !extSync_r[2])
                                : (!extSync_r[1] && extSync_r[2]);
  assign cntEdge = edgeSel_r[0] ? (cntSync_r[1] && !cntSync_r[2])
                                : (!cntSync_r[1] && cntSync_r[2]);

  // Priority select of enabled requests
  assign periphPend    = |(pir_r & pie_r);
  assign enabledReq[0] = isc_r[EXT_FLAG_BIT] && isc_r[EXT_EN_BIT];
  assign enabledReq[1] = isc_r[TIMER0_FLAG_BIT] && isc_r[TIMER0_EN_BIT];
  assign enabledReq[2] = isc_r[CNT_FLAG_BIT] && isc_r[CNT_EN_BIT];
  assign enabledReq[3] = periphPend && isc_r[PERIPH_GROUP_BIT];
  assign anyEnabled    = |enabledReq;

  always_comb
  begin
    if (enabledReq[0])
      sel = SRC_EXT;
    else if (enabledReq[1])
      sel = SRC_TIMER0;
    else if (enabledReq[2])
      sel = SRC_CNT;
    else
      sel = SRC_PERIPH;
  end

  assign irqRequest = !gid_r && anyEnabled;
  assign take       = irqRequest && irqAccept;

  // Flag sets beat hardware and software clears
  assign flagSet = {cntEdge, timer0Overflow, extEdge};
  always_comb
  begin
    flagClr = 3'h0;
    if (take)
    begin
      case (sel)
        SRC_EXT:  flagClr[0] = 1'b1;
        SRC_TIMER0: flagClr[1] = 1'b1;
        SRC_CNT:  flagClr[2] = 1'b1;
        default:  flagClr = 3'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      isc_r <= IRQ_STATUS_RST;
    else
    begin
      isc_r[PERIPH_PEND_BIT] <= 1'b0;
      if (wrIsc)
        isc_r[PERIPH_GROUP_BIT:EXT_EN_BIT] <= wdat[PERIPH_GROUP_BIT:EXT_EN_BIT];
      for (int i = 0; i < 3; i++)
      begin
        if (flagSet[i])
          isc_r[EXT_FLAG_BIT + i] <= 1'b1;
        else if (flagClr[i])
          isc_r[EXT_FLAG_BIT + i] <= 1'b0;
        else if (wrIsc)
          isc_r[EXT_FLAG_BIT + i] <= wdat[EXT_FLAG_BIT + i];
      end
    end
  end

  // Peripheral flags; software clears them by writing zero
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      pir_r <= PERIPH_REQ_RST;
    else if (wrEn && aphase_r.index == PERIPH_REQ_IDX)
      pir_r <= wdat | periphEvent;
    else
      pir_r <= pir_r | periphEvent;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pie_r     <= PERIPH_EN_RST;
      edgeSel_r <= EDGE_SEL_RST;
    end
    else if (wrEn)
    begin
      if (aphase_r.index == PERIPH_EN_IDX)
        pie_r <= wdat;
      if (aphase_r.index == EDGE_SEL_IDX)
        edgeSel_r <= {wdat[EXT_EDGE_BIT], wdat[CNT_EDGE_BIT]};
    end
  end

  // Global disable: accept sets it, return clears it
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      gid_r <= 1'b1;
    else if (take)
      gid_r <= 1'b1;
    else if (returnOp)
      gid_r <= 1'b0;
    else if (wrEn && aphase_r.index == CORE_STATUS_IDX)
      gid_r <= wdat[GLOBAL_DIS_BIT];
  end
  assign globalIrqDisable = gid_r;

  // Vectoring outputs
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vector_r     <= RESET_VECTOR;
      vectorLoad_r <= 1'b0;
      push_r       <= 1'b0;
      pop_r        <= 1'b0;
    end
    else
    begin
      vectorLoad_r <= take;
      push_r       <= take;
      pop_r        <= returnOp && !take;
      if (take)
      begin
        case (sel)
          SRC_EXT:  vector_r <= EXT_VECTOR;
          SRC_TIMER0: vector_r <= TIMER0_VECTOR;
          SRC_CNT:  vector_r <= CNT_VECTOR;
          default:  vector_r <= PERIPH_VECTOR;
        endcase
      end
    end
  end
  assign vectorAddr = vector_r;
  assign vectorLoad = vectorLoad_r;
  assign stackPush  = push_r;
  assign stackPop   = pop_r;

  // Clearing an enable while its flag rises with global disable clear is a known hazard: it resets the core
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      forceReset_r <= 1'b0;
    else
      forceReset_r <= wrIsc && !gid_r && (
        (flagSet[0] && isc_r[EXT_EN_BIT] && !wdat[EXT_EN_BIT]) ||
        (flagSet[1] && isc_r[TIMER0_EN_BIT] && !wdat[TIMER0_EN_BIT]) ||
        (flagSet[2] && isc_r[CNT_EN_BIT] && !wdat[CNT_EN_BIT]) ||
        (|periphEvent && isc_r[PERIPH_GROUP_BIT] && !wdat[PERIPH_GROUP_BIT]));
  end
  assign forceReset = forceReset_r;

  // Wake ignores global disable; the flag stays for software to see
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      wake_r <= 1'b0;
    else
      wake_r <= anyEnabled;
  end
  assign wakeUp = wake_r;

  // Register read
  always_comb
  begin
    iscRead = isc_r;
    iscRead[PERIPH_PEND_BIT] = periphPend;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= 32'h0;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      if (rdTake)
      begin
        case (haddr[9:2])
          IRQ_STATUS_IDX:  rdata_r <= {24'h0, iscRead};
          CORE_STATUS_IDX: rdata_r <= {27'h0, gid_r, 4'h0};
          PERIPH_REQ_IDX:  rdata_r <= {24'h0, pir_r};
          PERIPH_EN_IDX:   rdata_r <= {24'h0, pie_r};
          EDGE_SEL_IDX:    rdata_r <= {24'h0, edgeSel_r, 6'h0};
          default:         rdata_r <= 32'h0;
        endcase
      end
      else
        rdata_r <= 32'h0;
    end
  end
  assign hrdata = rdata_r;

  // Reads sample in the address phase: a write still in its data phase shows on the next read
  assign rdTake = hready && hsel && htrans[1] && !hwrite && (haddr[31:10] == 22'h0)
                  && (haddr[1:0] == 2'h0) && (hsize == 3'h2);

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence takeSeq;
    irqRequest && irqAccept;
  endsequence

  no_req_disabled_a: assert property (gid_r |-> !irqRequest)
    else $error("request while globally disabled");
  take_sets_dis_a: assert property (takeSeq |=> gid_r && vectorLoad && stackPush)
    else $error("accept did not set disable and push");
  ext_vector_a: assert property (takeSeq and enabledReq[0] |=> vectorAddr == EXT_VECTOR)
    else $error("external pin vector not chosen first");
  ext_clear_a: assert property (takeSeq and sel == SRC_EXT && !extEdge
    |=> !isc_r[EXT_FLAG_BIT])
    else $error("external flag not cleared on vectoring");
  periph_keep_a: assert property (takeSeq and sel == SRC_PERIPH && !wrEn
    |=> pir_r == ($past(pir_r) | $past(periphEvent)))
    else $error("peripheral flags changed on vectoring");
  flag_set_a: assert property (timer0Overflow |=> isc_r[TIMER0_FLAG_BIT])
    else $error("timer0 flag not set");
  return_clr_a: assert property (returnOp && !(irqRequest && irqAccept)
    |=> !gid_r && stackPop)
    else $error("return did not clear disable");
  group_gate_a: assert property (!isc_r[PERIPH_GROUP_BIT] && enabledReq[2:0] == 3'h0
    |-> !irqRequest)
    else $error("peripheral request with group disabled");
  pend_read_a: assert property (rdTake && haddr[9:2] == IRQ_STATUS_IDX
    |=> hrdata[PERIPH_PEND_BIT] == |($past(pir_r) & $past(pie_r)))
    else $error("pending bit does not follow peripheral flags");
  pin_edge_a: assert property ($rose(extSync_r[1]) && edgeSel_r[1]
    |=> isc_r[EXT_FLAG_BIT])
    else $error("external edge not flagged");
  reset_a: assert property (forceReset |-> $past(wrIsc))
    else $error("forced reset without a status write");
  pin_fall_a: assert property ($fell(extSync_r[1]) && !edgeSel_r[1]
    |=> isc_r[EXT_FLAG_BIT])
    else $error("external falling edge not flagged");
  cnt_edge_a: assert property ($rose(cntSync_r[1]) && edgeSel_r[0]
    |=> isc_r[CNT_FLAG_BIT])
    else $error("counter pin edge not flagged");
  tmr_clear_a: assert property (takeSeq and sel == SRC_TIMER0 && !timer0Overflow
    |=> !isc_r[TIMER0_FLAG_BIT])
    else $error("timer0 flag not cleared on vectoring");
  cnt_clear_a: assert property (takeSeq and sel == SRC_CNT && !cntEdge
    |=> !isc_r[CNT_FLAG_BIT])
    else $error("counter pin flag not cleared on vectoring");
  cnt_vector_a: assert property (takeSeq and sel == SRC_CNT
    |=> vectorAddr == CNT_VECTOR)
    else $error("counter pin vector wrong");
  periph_vector_a: assert property (takeSeq and sel == SRC_PERIPH
    |=> vectorAddr == PERIPH_VECTOR)
    else $error("peripheral vector wrong");
  force_gate_a: assert property (forceReset |-> !$past(gid_r))
    else $error("forced reset while globally disabled");

endmodule // core_interrupt_controller

// ==== logic/irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] EDGE_SEL_IDX    = 8'h05;
  localparam logic [7:0] CORE_STATUS_IDX = 8'h06;
  localparam logic [7:0] IRQ_STATUS_IDX  = 8'h07;
  localparam logic [7:0] PERIPH_REQ_IDX  = 8'h16;
  localparam logic [7:0] PERIPH_EN_IDX   = 8'h17;

  // Field positions in irq_status_control
  localparam int PERIPH_PEND_BIT  = 7;
  localparam int CNT_FLAG_BIT     = 6;
  localparam int TIMER0_FLAG_BIT    = 5;
  localparam int EXT_FLAG_BIT     = 4;
  localparam int PERIPH_GROUP_BIT = 3;
  localparam int CNT_EN_BIT       = 2;
  localparam int TIMER0_EN_BIT      = 1;
  localparam int EXT_EN_BIT       = 0;

  // Field positions elsewhere
  localparam int GLOBAL_DIS_BIT = 4;
  localparam int EXT_EDGE_BIT   = 7;
  localparam int CNT_EDGE_BIT   = 6;

  // Values after reset
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic [7:0] PERIPH_REQ_RST = 8'h02;
  localparam logic [7:0] PERIPH_EN_RST  = 8'h00;
  localparam logic [1:0] EDGE_SEL_RST   = 2'h0;

  // Vector addresses
  localparam logic [15:0] RESET_VECTOR  = 16'h0000;
  localparam logic [15:0] EXT_VECTOR    = 16'h0008;
  localparam logic [15:0] TIMER0_VECTOR   = 16'h0010;
  localparam logic [15:0] CNT_VECTOR    = 16'h0018;
  localparam logic [15:0] PERIPH_VECTOR = 16'h0020;

  localparam int NUM_SOURCES = 11;

  typedef enum logic [1:0] {SRC_EXT, SRC_TIMER0, SRC_CNT, SRC_PERIPH} src_type;

  // Captured AHB address phase
  typedef struct packed {
    logic       active;
    logic       write;
    logic [7:0] index;
    logic       aligned;
  } addr_phase_type;

endpackage

// ==== tb/core_seq_model.sv ====
`timescale 1ns/1ns
module core_seq_model
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Control from the bench
  input  wire logic       acceptEn,
  input  wire logic [1:0] acceptDelay,
  // Controller side
  input  wire logic       irqRequest,
  input  wire logic       stackPush,
  input  wire logic       stackPop,
  output logic            irqAccept,
  output logic [4:0]      stackDepth
);
  logic [1:0] waitCnt_r;

  // Slow answers let the request stand several cycles before it is taken
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitCnt_r <= 2'h0;
      irqAccept <= 1'b0;
    end
    else
    begin
      waitCnt_r <= irqRequest ? waitCnt_r + 2'h1 : 2'h0;
      irqAccept <= irqRequest && acceptEn && !irqAccept && (waitCnt_r == acceptDelay);
    end
  end

  // Stack depth of the core
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      stackDepth <= 5'h00;
    else if (stackPush && !stackPop)
      stackDepth <= stackDepth + 5'h01;
    else if (stackPop && !stackPush)
      stackDepth <= stackDepth - 5'h01;
  end
endmodule // core_seq_model

// ==== tb/core_interrupt_controller_tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module core_interrupt_controller_tb;
  import irq_ctrl_pkg::*;
  logic        mclk = 0, arst_n = 0, hsel = 0, hwrite = 0, returnOp = 0;
  logic        extIrqPin = 1, counterClockPin = 1, timer0Overflow = 0, acceptEn = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdData;
  logic [1:0]  htrans = 0, acceptDelay = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  periphEvent = 0;
  logic [15:0] vectorAddr;
  logic [4:0]  stackDepth;
  logic [3:0]  resetCnt = 0;
  logic        hready, hreadyout, hresp, irqAccept, irqRequest, vectorLoad;
  logic        stackPush, stackPop, forceReset, wakeUp, globalIrqDisable;
  int          miscompares = 0, cmp_count = 0;

  assign hready = hreadyout;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (forceReset === 1'b1) resetCnt <= resetCnt + 4'h1;

  core_interrupt_controller core_interrupt_controller_inst (.mclk(mclk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .extIrqPin(extIrqPin), .counterClockPin(counterClockPin),
    .timer0Overflow(timer0Overflow), .periphEvent(periphEvent), .irqAccept(irqAccept),
    .returnOp(returnOp), .irqRequest(irqRequest), .vectorAddr(vectorAddr),
    .vectorLoad(vectorLoad), .stackPush(stackPush), .stackPop(stackPop),
    .forceReset(forceReset), .wakeUp(wakeUp), .globalIrqDisable(globalIrqDisable));

  core_seq_model core_seq_model_inst (.mclk(mclk), .arst_n(arst_n), .acceptEn(acceptEn),
    .acceptDelay(acceptDelay), .irqRequest(irqRequest), .stackPush(stackPush),
    .stackPop(stackPop), .irqAccept(irqAccept), .stackDepth(stackDepth));

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic waitReady();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                      input logic tmr);
    hsel   <= 1'b1;
    haddr  <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    waitReady();
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    timer0Overflow <= tmr;
    waitReady();
    rdData = hrdata;
    if (tmr)
      timer0Overflow <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(idx, 1'b0, 8'h00, 1'b0);
    `CHK(rdData, exp)
  endtask

  task automatic waitVec(input logic [15:0] exp);
    int n;
    for (n = 0; n < 50 && vectorLoad !== 1'b1; n++)
      @(posedge mclk);
    `CHK(vectorLoad, 1'b1)
    `CHK(vectorAddr, exp)
    if (n >= 50)
      end_of_test();
    @(posedge mclk);
    `CHK(globalIrqDisable, 1'b1)
  endtask

  task automatic pulseRet();
    @(posedge mclk);
    returnOp <= 1'b1;
    @(posedge mclk);
    returnOp <= 1'b0;
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    `CHK(globalIrqDisable, 1'b1)
    rdChk(IRQ_STATUS_IDX, 32'h00000000);
    rdChk(CORE_STATUS_IDX, 32'h00000010);
    rdChk(PERIPH_REQ_IDX, 32'h00000002);
    rdChk(8'h3f, 32'h00000000);
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    // Disable is already set before enables are touched
    xfer(IRQ_STATUS_IDX, 1'b1, 8'h07, 1'b0);
    timer0Overflow <= 1'b1;
    periphEvent <= 8'h01;
    extIrqPin <= 1'b0;
    counterClockPin <= 1'b0;
    @(posedge mclk);
    timer0Overflow <= 1'b0;
    periphEvent <= 8'h00;
    repeat (5) @(posedge mclk);
    rdChk(IRQ_STATUS_IDX, 32'h00000077);
    rdChk(PERIPH_REQ_IDX, 32'h00000003);
    `CHK(irqRequest, 1'b0)
    `CHK(wakeUp, 1'b1)
    acceptDelay <= 2'h2;
    xfer(CORE_STATUS_IDX, 1'b1, 8'h00, 1'b0);
    waitVec(EXT_VECTOR);
    `CHK(stackDepth, 5'h01)
    rdChk(IRQ_STATUS_IDX, 32'h00000067);
    pulseRet();
    waitVec(TIMER0_VECTOR);
    rdChk(IRQ_STATUS_IDX, 32'h00000047);
    pulseRet();
    waitVec(CNT_VECTOR);
    rdChk(IRQ_STATUS_IDX, 32'h00000007);
    xfer(PERIPH_EN_IDX, 1'b1, 8'h01, 1'b0);
    rdChk(IRQ_STATUS_IDX, 32'h00000087);
    pulseRet();
    repeat (4) @(posedge mclk);
    `CHK(globalIrqDisable, 1'b0)
    `CHK(irqRequest, 1'b0)
    `CHK(stackDepth, 5'h00)
    acceptDelay <= 2'h0;
    xfer(IRQ_STATUS_IDX, 1'b1, 8'h0f, 1'b0);
    waitVec(PERIPH_VECTOR);
    rdChk(PERIPH_REQ_IDX, 32'h00000003);
    xfer(PERIPH_REQ_IDX, 1'b1, 8'h00, 1'b0);
    rdChk(IRQ_STATUS_IDX, 32'h0000000f);
    xfer(IRQ_STATUS_IDX, 1'b1, 8'h02, 1'b0);
    pulseRet();
    repeat (3) @(posedge mclk);
    `CHK(resetCnt, 4'h0)
    xfer(IRQ_STATUS_IDX, 1'b1, 8'h00, 1'b1);
    repeat (3) @(posedge mclk);
    `CHK(resetCnt, 4'h1)
    `CHK(irqRequest, 1'b0)
    xfer(EDGE_SEL_IDX, 1'b1, 8'hc0, 1'b0);
    rdChk(EDGE_SEL_IDX, 32'h000000c0);
    extIrqPin <= 1'b1;
    counterClockPin <= 1'b1;
    repeat (5) @(posedge mclk);
    rdChk(IRQ_STATUS_IDX, 32'h00000070);
    end_of_test();
  end
endmodule // core_interrupt_controller_tb
